//--- src/fault_warning_reporting.v
// fault and warning flags, fault pin masking and latch control registers
`timescale 1ns/1ps
`default_nettype none
`include "fault_defs.vh"
module fault_warning_reporting (
   // clock and reset
   input  wire       sys_clk,
   input  wire       arst_n,
   // register port from the control interface
   input  wire [7:0] reg_addr,
   input  wire       reg_wr_en,
   input  wire [7:0] reg_wdata,
   input  wire       reg_rd_en,
   output reg  [7:0] reg_rdata,
   // analog detectors, asynchronous levels
   input  wire       thermal_shutdown_det,
   input  wire [3:0] thermal_warn_det,
   input  wire       left_limit_fault_det,
   input  wire       right_limit_fault_det,
   input  wire       left_limit_warn_det,
   input  wire       right_limit_warn_det,
   input  wire       clock_error_det,
   input  wire       clock_detect_det,
   // flags of other fault registers, same clock
   input  wire       core_supply_under,
   input  wire       core_supply_over,
   input  wire       power_supply_under,
   input  wire       power_supply_over,
   input  wire       dc_offset_fault,
   input  wire       overcurrent_fault,
   // outputs
   output reg        fault_pin_n,
   output reg        output_stage_hiz,
   output reg        analog_fault_clear,
   output wire       current_limit_enable,
   output wire       clock_error_flag,
   output wire       clock_detect_status
);
   // control registers
   reg  [7:0] fault_pin_mask_primary;
   reg  [7:0] latch_and_mask_control;
   reg  [7:0] misc_protection_control;
   reg  [7:0] current_limit_control;

   // synchronised detector levels
   wire [3:0] thermal_warn_live;
   wire       thermal_shutdown_live;
   wire       left_fault_live;
   wire       right_fault_live;
   wire       left_warn_live;
   wire       right_warn_live;
   wire       clock_error_live;
   wire       clock_detect_live;

   // flags
   wire       thermal_shutdown_flag;
   wire [3:0] thermal_warn_flags;
   wire [1:0] limit_fault_flags;
   wire [1:0] limit_warn_flags;
   wire       clock_detect_held;

   wire       clear_pulse;
   wire       current_limit_warning_enable;
   wire       current_limit_fault_enable;
   wire       thermal_auto_recovery_enable;
   wire       clock_detect_hold;
   wire [7:0] global_fault_status_two;
   wire [7:0] warning_flags;
   wire       any_fault;
   reg  [7:0] next_rdata;

   // named register fields, so masks and latches read as they are meant
   wire       thermal_shutdown_pin_mask;
   wire       core_supply_under_mask;
   wire       core_supply_over_mask;
   wire       clock_error_pin_mask;
   wire       power_supply_volt_mask;
   wire       dc_offset_pin_mask;
   wire       overcurrent_pin_mask;
   wire       thermal_warning_pin_mask;
   wire       limit_warning_pin_mask;
   wire       limit_fault_pin_mask;
   wire       limit_fault_latch_enable;
   wire       limit_warning_latch_enable;
   wire       clock_error_latch_enable;
   wire       thermal_shutdown_latch_enable;
   wire       thermal_warning_latch_enable;

   // one report term per source; the fault pin is their or
   wire       report_shutdown;
   wire       report_core_under;
   wire       report_core_over;
   wire       report_clock;
   wire       report_power;
   wire       report_dc;
   wire       report_overcurrent;
   wire       report_therm_warn;
   wire       report_limit_warn;
   wire       report_limit_fault;

   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // a write strobe aimed at one offset
   function write_hit;
      input       wr_en;
      input [7:0] addr;
      input [7:0] target;
      begin
         write_hit = wr_en & hit(addr, target);
      end
   endfunction

   input_sync3 #(.WIDTH(11)) u_sync (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .async_in ({thermal_shutdown_det, thermal_warn_det,
                  left_limit_fault_det, right_limit_fault_det,
                  left_limit_warn_det, right_limit_warn_det,
                  clock_error_det, clock_detect_det}),
      .sync_out ({thermal_shutdown_live, thermal_warn_live,
                  left_fault_live, right_fault_live,
                  left_warn_live, right_warn_live,
                  clock_error_live, clock_detect_live})
   );

   // register writes; reserved bits are never stored
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_pin_mask_primary <= `RST_PIN_MASK;
      end else if (write_hit(reg_wr_en, reg_addr, `ADDR_PIN_MASK)) begin
         fault_pin_mask_primary <= reg_wdata & `PIN_MASK_USED;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         latch_and_mask_control <= `RST_LATCH_CTRL;
      end else if (write_hit(reg_wr_en, reg_addr, `ADDR_LATCH_CTRL)) begin
         latch_and_mask_control <= reg_wdata;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         misc_protection_control <= `RST_MISC_CTRL;
      end else if (write_hit(reg_wr_en, reg_addr, `ADDR_MISC_CTRL)) begin
         misc_protection_control <= reg_wdata & `MISC_CTRL_USED;
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         current_limit_control <= `RST_LIMIT_CTRL;
      end else if (write_hit(reg_wr_en, reg_addr, `ADDR_LIMIT_CTRL)) begin
         current_limit_control <= reg_wdata & `LIMIT_CTRL_USED;
      end
   end

   // clear acts on the write only and is never stored
   assign clear_pulse = write_hit(reg_wr_en, reg_addr, `ADDR_FAULT_CLEAR)
                        & reg_wdata[`BIT_CLEAR];

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         analog_fault_clear <= 1'b0;
      end else begin
         analog_fault_clear <= clear_pulse;
      end
   end

   assign current_limit_enable =
      current_limit_control[`BIT_LIM_EN];
   assign current_limit_warning_enable = current_limit_enable
      & current_limit_control[`BIT_LIM_WARN_EN];
   assign current_limit_fault_enable = current_limit_enable
      & current_limit_control[`BIT_LIM_FAULT_EN];
   assign thermal_auto_recovery_enable =
      misc_protection_control[`BIT_MISC_AUTO_REC];
   assign clock_detect_hold =
      misc_protection_control[`BIT_MISC_DET_HOLD];

   assign thermal_shutdown_pin_mask =
      fault_pin_mask_primary[`BIT_MSK_SHUTDOWN];
   assign core_supply_under_mask =
      fault_pin_mask_primary[`BIT_MSK_CORE_UNDER];
   assign core_supply_over_mask =
      fault_pin_mask_primary[`BIT_MSK_CORE_OVER];
   assign clock_error_pin_mask =
      fault_pin_mask_primary[`BIT_MSK_CLOCK];
   assign power_supply_volt_mask =
      fault_pin_mask_primary[`BIT_MSK_POWER_VOLT];
   assign dc_offset_pin_mask =
      fault_pin_mask_primary[`BIT_MSK_DC];
   assign overcurrent_pin_mask =
      fault_pin_mask_primary[`BIT_MSK_OC];
   assign thermal_warning_pin_mask =
      latch_and_mask_control[`BIT_MSK_THERM_WARN];
   assign limit_warning_pin_mask =
      latch_and_mask_control[`BIT_MSK_LIM_WARN];
   assign limit_fault_pin_mask =
      latch_and_mask_control[`BIT_MSK_LIM_FAULT];
   assign limit_fault_latch_enable =
      latch_and_mask_control[`BIT_LAT_LIM_FAULT];
   assign limit_warning_latch_enable =
      latch_and_mask_control[`BIT_LAT_LIM_WARN];
   assign clock_error_latch_enable =
      latch_and_mask_control[`BIT_LAT_CLOCK];
   assign thermal_shutdown_latch_enable =
      latch_and_mask_control[`BIT_LAT_SHUTDOWN];
   assign thermal_warning_latch_enable =
      latch_and_mask_control[`BIT_LAT_THERM_WARN];

   status_flag #(.WIDTH(1)) u_shutdown (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (thermal_shutdown_latch_enable),
      .clear    (clear_pulse),
      .live     (thermal_shutdown_live),
      .flag     (thermal_shutdown_flag)
   );

   status_flag #(.WIDTH(4)) u_therm_warn (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (thermal_warning_latch_enable),
      .clear    (clear_pulse),
      .live     (thermal_warn_live),
      .flag     (thermal_warn_flags)
   );

   // index 1 is right, index 0 is left
   status_flag #(.WIDTH(2)) u_limit_fault (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (limit_fault_latch_enable),
      .clear    (clear_pulse),
      .live     ({right_fault_live, left_fault_live}
                 & {2{current_limit_fault_enable}}),
      .flag     (limit_fault_flags)
   );

   // index 1 is left, index 0 is right
   status_flag #(.WIDTH(2)) u_limit_warn (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (limit_warning_latch_enable),
      .clear    (clear_pulse),
      .live     ({left_warn_live, right_warn_live}
                 & {2{current_limit_warning_enable}}),
      .flag     (limit_warn_flags)
   );

   status_flag #(.WIDTH(1)) u_clock_error (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (clock_error_latch_enable),
      .clear    (clear_pulse),
      .live     (clock_error_live),
      .flag     (clock_error_flag)
   );

   status_flag #(.WIDTH(1)) u_clock_detect (
      .sys_clk  (sys_clk),
      .arst_n   (arst_n),
      .latch_en (clock_detect_hold),
      .clear    (clear_pulse),
      .live     (clock_detect_live),
      .flag     (clock_detect_held)
   );

   assign clock_detect_status = clock_detect_held;

   // without auto-recovery the stage stays off until a clear, even after
   // the die has cooled, so a hot part is not cycled on and off by itself
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         output_stage_hiz <= 1'b0;
      end else if (thermal_shutdown_live) begin
         output_stage_hiz <= 1'b1;
      end else if (thermal_auto_recovery_enable) begin
         output_stage_hiz <= 1'b0;
      end else if (clear_pulse) begin
         output_stage_hiz <= 1'b0;
      end
   end

   assign global_fault_status_two = {5'h00, limit_fault_flags,
                                     thermal_shutdown_flag};
   assign warning_flags = {2'h0, limit_warn_flags,
                           thermal_warn_flags};

   assign report_shutdown =
      thermal_shutdown_flag & ~thermal_shutdown_pin_mask;
   assign report_core_under =
      core_supply_under & ~core_supply_under_mask;
   assign report_core_over =
      core_supply_over & ~core_supply_over_mask;
   assign report_clock =
      clock_error_flag & ~clock_error_pin_mask;
   assign report_power = (power_supply_under | power_supply_over)
      & ~power_supply_volt_mask;
   assign report_dc =
      dc_offset_fault & ~dc_offset_pin_mask;
   assign report_overcurrent =
      overcurrent_fault & ~overcurrent_pin_mask;
   assign report_therm_warn =
      (|thermal_warn_flags) & ~thermal_warning_pin_mask;
   assign report_limit_warn =
      (|limit_warn_flags) & ~limit_warning_pin_mask;
   assign report_limit_fault =
      (|limit_fault_flags) & ~limit_fault_pin_mask;

   assign any_fault = report_shutdown | report_core_under | report_core_over
      | report_clock | report_power | report_dc | report_overcurrent
      | report_therm_warn | report_limit_warn | report_limit_fault;

   // pin is active low so an unpowered pull-up reads as no fault
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         fault_pin_n <= 1'b1;
      end else begin
         fault_pin_n <= ~any_fault;
      end
   end

   always @* begin
      next_rdata = 8'h00;
      case (reg_addr)
         `ADDR_STATUS_TWO:    next_rdata = global_fault_status_two;
         `ADDR_WARNING_FLAGS: next_rdata = warning_flags;
         `ADDR_PIN_MASK:      next_rdata = fault_pin_mask_primary;
         `ADDR_LATCH_CTRL:    next_rdata = latch_and_mask_control;
         `ADDR_MISC_CTRL:     next_rdata = misc_protection_control;
         `ADDR_LIMIT_CTRL:    next_rdata = current_limit_control;
         default:             next_rdata = 8'h00;
      endcase
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata <= next_rdata;
      end
   end
endmodule // fault_warning_reporting
`default_nettype wire

//--- src/fault_defs.vh
// offsets, field positions and reset values of the fault and warning block
//
// Contract
// - thermal shutdown sets status-two bit 0 and puts class-D outputs in hi-z
// - with auto-recovery, outputs resume once the shutdown condition is gone
// - shutdown flag stays 1 until software writes 1 to clear bit 7
// - an unmasked shutdown flag asserts the shared fault pin
// - limit faults: right in status-two bit 2, left in bit 1, read-only
// - current-limit warnings: left in warning bit 5, right bit 4, read-only
// - four thermal warning levels in warning bits 0 to 3, read-only
// - pin-mask register bits set to 1 keep their fault off the pin
// - pin-mask bit 2 masks both power-supply under- and over-voltage
// - latch-control bits 7 to 3 enable latching; register resets to F8
// - latch-control bits 2..0 mask thermal warn, limit warn, limit fault
// - misc bit 7 holds clock-detect status when 1; resets to 0
// - misc bit 4 enables thermal shutdown auto-recovery; resets to 0
// - writing 1 to bit 7 at offset 78 clears latched faults; write-only
`ifndef FAULT_DEFS_VH
`define FAULT_DEFS_VH

`define ADDR_STATUS_TWO      8'h72
`define ADDR_WARNING_FLAGS   8'h73
`define ADDR_PIN_MASK        8'h74
`define ADDR_LATCH_CTRL      8'h75
`define ADDR_MISC_CTRL       8'h76
`define ADDR_LIMIT_CTRL      8'h77
`define ADDR_FAULT_CLEAR     8'h78

`define RST_PIN_MASK         8'h00
`define RST_LATCH_CTRL       8'hF8
`define RST_MISC_CTRL        8'h00
`define RST_LIMIT_CTRL       8'h00

`define PIN_MASK_USED        8'hF7
`define MISC_CTRL_USED       8'h90
`define LIMIT_CTRL_USED      8'h07

`define BIT_CLEAR            7
`define BIT_MISC_DET_HOLD    7
`define BIT_MISC_AUTO_REC    4
`define BIT_LIM_EN           2
`define BIT_LIM_WARN_EN      1
`define BIT_LIM_FAULT_EN     0
`define BIT_LAT_LIM_FAULT    7
`define BIT_LAT_LIM_WARN     6
`define BIT_LAT_CLOCK        5
`define BIT_LAT_SHUTDOWN     4
`define BIT_LAT_THERM_WARN   3
`define BIT_MSK_THERM_WARN   2
`define BIT_MSK_LIM_WARN     1
`define BIT_MSK_LIM_FAULT    0
`define BIT_MSK_SHUTDOWN     7
`define BIT_MSK_CORE_UNDER   6
`define BIT_MSK_CORE_OVER    5
`define BIT_MSK_CLOCK        4
`define BIT_MSK_POWER_VOLT   2
`define BIT_MSK_DC           1
`define BIT_MSK_OC           0

`endif

//--- src/input_sync3.v
// three-stage synchroniser for detector levels from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module input_sync3 #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             sys_clk,
   input  wire             arst_n,
   // levels
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;

   // a bit changes only once stages two and three agree, hiding glitches
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1   <= {WIDTH{1'b0}};
         stage2   <= {WIDTH{1'b0}};
         stage3   <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         stage1   <= async_in;
         stage2   <= stage1;
         stage3   <= stage2;
         sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
      end
   end
endmodule // input_sync3
`default_nettype wire

//--- src/status_flag.v
// status flags that either hold until cleared or follow the live condition
`timescale 1ns/1ps
`default_nettype none
module status_flag #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             sys_clk,
   input  wire             arst_n,
   // control
   input  wire             latch_en,
   input  wire             clear,
   // condition and flag
   input  wire [WIDTH-1:0] live,
   output reg  [WIDTH-1:0] flag
);
   wire [WIDTH-1:0] next_flag;

   // a live condition always sets, so a clear in the same cycle loses
   assign next_flag = live | ({WIDTH{latch_en & ~clear}} & flag);

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flag <= {WIDTH{1'b0}};
      end else begin
         flag <= next_flag;
      end
   end
endmodule // status_flag
`default_nettype wire

//--- tb/fault_warning_reporting_sva.sv
// assertions on the ports of the fault and warning block
`timescale 1ns/1ps
`default_nettype none
module fault_warning_reporting_sva (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       arst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_rd_en,
   input wire logic [7:0] reg_rdata,
   // detector and outputs
   input wire logic       thermal_shutdown_det,
   input wire logic       output_stage_hiz,
   input wire logic       analog_fault_clear,
   input wire logic       current_limit_enable
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   wire clr_wr = reg_wr_en && reg_addr == 8'h78 && reg_wdata[7];
   a_clear_pulse_out:
      assert property (clr_wr |=> ##[0:1] analog_fault_clear)
         else $error("clear pulse missing");
   a_clear_pulse_cause:
      assert property (analog_fault_clear
         |-> $past(clr_wr) || $past(clr_wr, 2))
         else $error("clear pulse without a clear write");
   a_hiz_on_shutdown:
      assert property (thermal_shutdown_det [*8] |-> output_stage_hiz)
         else $error("outputs not hi-z during shutdown");
   a_clear_reads_zero:
      assert property (reg_rd_en && reg_addr == 8'h78 |=> reg_rdata == 8'h00)
         else $error("clear register read not zero");
   a_status_reserved:
      assert property (reg_rd_en && reg_addr == 8'h72
         |=> reg_rdata[7:3] == 5'h00)
         else $error("status reserved bits not zero");
   a_warn_reserved:
      assert property (reg_rd_en && reg_addr == 8'h73
         |=> reg_rdata[7:6] == 2'h0)
         else $error("warning reserved bits not zero");
   a_limit_reserved:
      assert property (reg_rd_en && reg_addr == 8'h77
         |=> reg_rdata[7:3] == 5'h00)
         else $error("limiter reserved bits not zero");
   a_limit_en_write:
      assert property (reg_wr_en && reg_addr == 8'h77
         |=> current_limit_enable == $past(reg_wdata[2]))
         else $error("limiter enable not taken from write");
endmodule // fault_warning_reporting_sva
bind fault_warning_reporting fault_warning_reporting_sva chk_i (
   .sys_clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
   .reg_rdata, .thermal_shutdown_det, .output_stage_hiz,
   .analog_fault_clear, .current_limit_enable);
`default_nettype wire

//--- tb/host_port_model.sv
// host model driving the byte register port
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
   // clock
   input  wire logic       sys_clk,
   // register port
   output var  logic [7:0] reg_addr,
   output var  logic       reg_wr_en,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_rd_en,
   input  wire logic [7:0] reg_rdata
);
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
   end
   // released fields show the inverse so a stale value is never trusted
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge sys_clk);
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge sys_clk);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask
endmodule // host_port_model
`default_nettype wire

//--- tb/test_fault_warning_reporting.sv
// self-checking bench for the fault and warning block
`timescale 1ns/1ps
`default_nettype none
module test_fault_warning_reporting;
   logic       sys_clk = 1'b0;
   logic       arst_n = 1'b0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic       reg_wr_en, reg_rd_en, pin_n, hiz, lim_en;
   logic       tsd = 1'b0, lfd = 1'b0, rfd = 1'b0, lwd = 1'b0, rwd = 1'b0;
   logic [3:0] twd = 4'h0;
   logic [5:0] sup = 6'h00;
   logic       ced = 1'b0, cdd = 1'b0, afc, clk_err, clk_det;
   int         fail_count = 0;
   int         checks_done = 0;
   int         mb[6] = '{0, 1, 2, 2, 5, 6};
   fault_warning_reporting uut (
      .sys_clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
      .reg_rdata, .thermal_shutdown_det(tsd), .thermal_warn_det(twd),
      .left_limit_fault_det(lfd), .right_limit_fault_det(rfd),
      .left_limit_warn_det(lwd), .right_limit_warn_det(rwd),
      .clock_error_det(ced), .clock_detect_det(cdd),
      .core_supply_under(sup[5]), .core_supply_over(sup[4]),
      .power_supply_under(sup[3]), .power_supply_over(sup[2]),
      .dc_offset_fault(sup[1]), .overcurrent_fault(sup[0]),
      .fault_pin_n(pin_n), .output_stage_hiz(hiz),
      .analog_fault_clear(afc), .current_limit_enable(lim_en),
      .clock_error_flag(clk_err), .clock_detect_status(clk_det));
   host_port_model host (
      .sys_clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata);
   initial forever #2 sys_clk = ~sys_clk;
   task automatic chk(input string n, input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic ck1(input string n, input logic s, input logic e);
      chk(n, {7'h00, s}, {7'h00, e});
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.rd(a, d);
      chk($sformatf("reg %h", a), d, e);
   endtask
   // detectors pass a synchroniser, so ten cycles cover flag and pin
   task automatic w(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic clear;
      host.wr(8'h78, 8'h80);
      ck1("clear pulse", afc, 1'b1);
      w(1);
      ck1("clear pulse", afc, 1'b0);
      w(1);
   endtask
   task automatic t_reset;
      rdc(8'h72, 8'h00);
      rdc(8'h73, 8'h00);
      rdc(8'h74, 8'h00);
      rdc(8'h75, 8'hF8);
      rdc(8'h76, 8'h00);
      rdc(8'h77, 8'h00);
      ck1("fault pin", pin_n, 1'b1);
   endtask
   task automatic t_reserved;
      host.wr(8'h74, 8'hFF);
      rdc(8'h74, 8'hF7);
      host.wr(8'h76, 8'hFF);
      rdc(8'h76, 8'h90);
      host.wr(8'h77, 8'hFF);
      rdc(8'h77, 8'h07);
      host.wr(8'h75, 8'h00);
      rdc(8'h75, 8'h00);
      host.wr(8'h72, 8'hFF);
      rdc(8'h72, 8'h00);
      host.wr(8'h73, 8'hFF);
      rdc(8'h73, 8'h00);
      rdc(8'h40, 8'h00);
      rdc(8'h78, 8'h00);
      host.wr(8'h74, 8'h00);
      host.wr(8'h75, 8'hF8);
      host.wr(8'h76, 8'h00);
      host.wr(8'h77, 8'h00);
   endtask
   task automatic t_shutdown;
      tsd = 1'b1;
      w(10);
      rdc(8'h72, 8'h01);
      ck1("hiz", hiz, 1'b1);
      ck1("fault pin", pin_n, 1'b0);
      tsd = 1'b0;
      w(10);
      host.wr(8'h78, 8'h7F);
      ck1("clear pulse", afc, 1'b0);
      w(2);
      rdc(8'h72, 8'h01);
      ck1("hiz", hiz, 1'b1);
      clear;
      rdc(8'h72, 8'h00);
      ck1("hiz", hiz, 1'b0);
      ck1("fault pin", pin_n, 1'b1);
      host.wr(8'h74, 8'h80);
      tsd = 1'b1;
      w(10);
      ck1("fault pin", pin_n, 1'b1);
      tsd = 1'b0;
      host.wr(8'h74, 8'h00);
      host.wr(8'h76, 8'h10);
      w(10);
      ck1("hiz", hiz, 1'b0);
      rdc(8'h72, 8'h01);
      host.wr(8'h76, 8'h00);
      clear;
      host.wr(8'h75, 8'hE8);
      tsd = 1'b1;
      w(10);
      rdc(8'h72, 8'h01);
      tsd = 1'b0;
      w(10);
      rdc(8'h72, 8'h00);
      host.wr(8'h75, 8'hF8);
      clear;
   endtask
   task automatic t_warn;
      host.wr(8'h75, 8'hF0);
      for (int i = 0; i < 4; i++) begin
         twd = 4'h1 << i;
         w(10);
         rdc(8'h73, 8'h01 << i);
         ck1("fault pin", pin_n, 1'b0);
      end
      host.wr(8'h75, 8'hF4);
      twd = 4'hF;
      w(10);
      rdc(8'h73, 8'h0F);
      ck1("fault pin", pin_n, 1'b1);
      twd = 4'h0;
      w(10);
      rdc(8'h73, 8'h00);
      host.wr(8'h75, 8'hF8);
   endtask
   task automatic t_limit;
      lfd = 1'b1;
      rwd = 1'b1;
      w(10);
      rdc(8'h72, 8'h00);
      host.wr(8'h77, 8'h07);
      w(10);
      ck1("limiter", lim_en, 1'b1);
      rdc(8'h72, 8'h02);
      rdc(8'h73, 8'h10);
      ck1("fault pin", pin_n, 1'b0);
      {lfd, rwd, rfd, lwd} = 4'h3;
      w(10);
      rdc(8'h72, 8'h06);
      rdc(8'h73, 8'h30);
      host.wr(8'h75, 8'hFB);
      w(3);
      ck1("fault pin", pin_n, 1'b1);
      {rfd, lwd} = 2'h0;
      w(10);
      clear;
      rdc(8'h72, 8'h00);
      host.wr(8'h77, 8'h00);
      host.wr(8'h75, 8'hF8);
   endtask
   task automatic t_supply;
      for (int k = 0; k < 6; k++) begin
         sup = 6'h01 << k;
         w(3);
         ck1("fault pin", pin_n, 1'b0);
         host.wr(8'h74, 8'h01 << mb[k]);
         w(3);
         ck1("fault pin", pin_n, 1'b1);
         sup = 6'h00;
         host.wr(8'h74, 8'h00);
      end
   endtask
   task automatic t_clock;
      ced = 1'b1;
      w(10);
      ck1("clock error", clk_err, 1'b1);
      ck1("fault pin", pin_n, 1'b0);
      host.wr(8'h74, 8'h10);
      w(3);
      ck1("fault pin", pin_n, 1'b1);
      ced = 1'b0;
      w(10);
      ck1("clock error", clk_err, 1'b1);
      clear;
      ck1("clock error", clk_err, 1'b0);
      host.wr(8'h75, 8'hD8);
      ced = 1'b1;
      w(10);
      ck1("clock error", clk_err, 1'b1);
      ced = 1'b0;
      w(10);
      ck1("clock error", clk_err, 1'b0);
      cdd = 1'b1;
      w(10);
      ck1("clock detect", clk_det, 1'b1);
      cdd = 1'b0;
      w(10);
      ck1("clock detect", clk_det, 1'b0);
      host.wr(8'h76, 8'h80);
      cdd = 1'b1;
      w(10);
      cdd = 1'b0;
      w(10);
      ck1("clock detect", clk_det, 1'b1);
      clear;
      ck1("clock detect", clk_det, 1'b0);
      host.wr(8'h75, 8'hF8);
      host.wr(8'h76, 8'h00);
      host.wr(8'h74, 8'h00);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20) @(negedge sys_clk);
      arst_n = 1'b1;
      t_reset;
      t_reserved;
      t_shutdown;
      t_warn;
      t_limit;
      t_clock;
      t_supply;
      tally_and_finish;
   end
   // the sequence needs well under 2000 cycles; allow ten times that
   initial begin
      #80000;
      fail_count++;
      tally_and_finish;
   end
endmodule // test_fault_warning_reporting
`default_nettype wire
